// *** hw/abt_regs.svh ***
`ifndef ABT_REGS_SVH
`define ABT_REGS_SVH
// ************************************************************
// Register map and field layout
// ************************************************************
`define ABT_ADDR_TIMING 6'h02
`define ABT_ADDR_OVERRIDE 6'h01
`define ABT_TIMING_RESET 16'h0000
`define ABT_OVERRIDE_RESET 16'h0000
`define ABT_EXT_DIS_HI 15
`define ABT_EXT_DIS_LO 14
`define ABT_INT_DIS_HI 13
`define ABT_INT_DIS_LO 8
`define ABT_ON_HI 7
`define ABT_ON_LO 3
`define ABT_BRK_HI 2
`define ABT_BRK_LO 1
`define ABT_PARITY_BIT 0
`define ABT_OVR_HI 15
`define ABT_OVR_LO 8
`define ABT_EMCY_HI 7
`define ABT_EMCY_LO 6
`define ABT_ACT_ON_WRITE_BIT 1
`define ABT_EMCY_CODE 2'h2
// ************************************************************
// Timing
// ************************************************************
`define ABT_CLK_HZ 10000000
`define ABT_MS_PER_S 1000
`define ABT_CYC_PER_MS (`ABT_CLK_HZ / `ABT_MS_PER_S)
`define ABT_ON_BASE_MS 100
`define ABT_ON_STEP_LO_MS 20
`define ABT_ON_BASE_HI_MS 440
`define ABT_ON_STEP_HI_MS 40
`define ABT_ON_SPLIT 5'h10
`define ABT_BRK_SHORT_MS 100
`define ABT_BRK_LONG_MS 200
`endif

// *** hw/abt_pkg.sv ***
package abt_pkg;
	typedef enum logic [1:0] {
		ABT_BRK_NONE,
		ABT_BRK_100,
		ABT_BRK_200,
		ABT_BRK_HOLD
	} abt_brake_code_t;
	typedef struct packed {
		logic [1:0] ext_brake_disable;
		logic [5:0] internal_brake_disable;
		logic [4:0] on_code;
		abt_brake_code_t brake_code;
		logic parity;
	} abt_timing_cfg_t;
	typedef struct packed {
		logic valid;
		logic [5:0] addr;
		logic [15:0] data;
	} abt_write_t;
endpackage

// *** hw/abt_timing.sv ***
`timescale 1ns/100ps
`include "abt_regs.svh"
// Operation
// [RL1] Writes during a timed actuation apply only to the next actuation.
// [RL2] Timing configuration stays unchanged after an actuation completes.
// [RL3] Bits 15,14 disable ext bridge 2,1 braking; bits 13..8 internal 6..1.
// [RL4] On-time code bits 7..3, brake code bits 2..1, parity bit 0.
// [RL5] Braking starts right when the on-time ends, no idle gap.
// [RL6] Brake every output except overridden or brake-disabled ones.
// [RL7] Braking turns low sides on for the full commanded brake time.
// [RL8] Brake code: 00 none, 01 100 ms, 10 200 ms, 11 100 ms then hold.
// [RL9] In hold braking, no new actuation before the first 100 ms pass.
// [RL10] Host reprograms brake code and retriggers to leave hold braking.
// [RL11] Entering emergency with actuate-on-write clear stops hold braking.
// [RL12] One on-time code serves all outputs of an actuation.
// [RL13] On-time: codes 0..15 are 100+20n ms, 16..31 are 440+40(n-16) ms.
// [RL14] A brake-disabled output is never braked.
// [RL15] Host frames each write as address, data, then parity.
// [RL16] Trigger on enable rise, or on chip-select rise with bit set and enable high; the code takes the enable rise only while the bit is clear.
// [RL17] Emergency only when emergency select equals one-zero.
// [RL18] An override bit holds its output on outside the timed sequence; the code does this only while the enable pin is high.
// [RL19] Durations counted by a millisecond tick from the trigger edge.
module abt_timing #(
	parameter int CYC_PER_MS = `ABT_CYC_PER_MS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	input wire abt_pkg::abt_write_t wr,
	input wire logic cs_rise,
	input wire logic enable_pin,
	output abt_pkg::abt_timing_cfg_t timing_cfg_q,
	output logic [15:0] override_q,
	output logic [7:0] drive_on_q,
	output logic [7:0] low_side_on_q,
	output logic actuating_q,
	output logic braking_q
);
	typedef enum logic [1:0] {ABT_IDLE, ABT_ON, ABT_BRAKE, ABT_HOLD} abt_state_t;

	// ************************************************************
	// Decoders
	// ************************************************************
	function automatic logic [10:0] abt_on_ms(input logic [4:0] code);
		if (code < `ABT_ON_SPLIT) begin
			abt_on_ms = 11'(`ABT_ON_BASE_MS + `ABT_ON_STEP_LO_MS * code); // RL13
		end else begin
			abt_on_ms = 11'(`ABT_ON_BASE_HI_MS + `ABT_ON_STEP_HI_MS * (code - `ABT_ON_SPLIT)); // RL13
		end
	endfunction

	function automatic logic [10:0] abt_brk_ms(input abt_pkg::abt_brake_code_t code);
		unique case (code) // RL8
			abt_pkg::ABT_BRK_NONE: abt_brk_ms = 11'h000;
			abt_pkg::ABT_BRK_200: abt_brk_ms = 11'(`ABT_BRK_LONG_MS);
			abt_pkg::ABT_BRK_100, abt_pkg::ABT_BRK_HOLD: abt_brk_ms = 11'(`ABT_BRK_SHORT_MS);
		endcase
	endfunction

	// ************************************************************
	// Synchronise the enable pin
	// ************************************************************
	logic en_s1_q, en_s2_q, en_s3_q;
	// Reset to the high level, so a pin that is already high at reset gives no false edge.
	always_ff @(posedge mclk) begin
		if (rst) begin
			en_s1_q <= 1'b1;
			en_s2_q <= 1'b1;
			en_s3_q <= 1'b1;
		end else if (clk_en) begin
			en_s1_q <= enable_pin;
			en_s2_q <= en_s1_q;
			en_s3_q <= en_s2_q;
		end
	end
	logic en_rise;
	assign en_rise = en_s2_q & ~en_s3_q;

	// ************************************************************
	// Registers and trigger
	// ************************************************************
	abt_pkg::abt_timing_cfg_t timing_cfg_d;
	logic [15:0] override_d;
	logic trig, emcy_enter, wr_ovr, wr_tim;
	assign wr_tim = wr.valid & (wr.addr == `ABT_ADDR_TIMING);
	assign wr_ovr = wr.valid & (wr.addr == `ABT_ADDR_OVERRIDE);
	// The written value is stored at once; a running actuation keeps its latched copy.
	always_comb begin
		timing_cfg_d = timing_cfg_q; // RL2
		override_d = override_q;
		if (wr_tim) begin
			timing_cfg_d = abt_pkg::abt_timing_cfg_t'(wr.data); // RL4 RL3
		end
		if (wr_ovr) begin
			override_d = wr.data;
		end
	end
	always_comb begin
		trig = 1'b0;
		if (override_q[`ABT_ACT_ON_WRITE_BIT]) begin
			trig = cs_rise & en_s2_q; // RL16
		end else begin
			trig = en_rise; // RL16
		end
	end
	// Emergency entered at any chip-select rise while the override emergency select bits hold one-zero.
	assign emcy_enter = cs_rise &
		(override_q[`ABT_EMCY_HI:`ABT_EMCY_LO] == `ABT_EMCY_CODE); // RL17

	always_ff @(posedge mclk) begin
		if (rst) begin
			timing_cfg_q <= abt_pkg::abt_timing_cfg_t'(`ABT_TIMING_RESET);
			override_q <= `ABT_OVERRIDE_RESET;
		end else if (clk_en) begin
			timing_cfg_q <= timing_cfg_d;
			override_q <= override_d;
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	abt_state_t state_q, state_d;
	abt_pkg::abt_timing_cfg_t run_q, run_d;
	logic [13:0] pre_q, pre_d;
	logic [10:0] ms_q, ms_d;
	logic tick, ms_done, may_start;
	assign tick = (pre_q == 14'(CYC_PER_MS - 1)); // RL19
	assign ms_done = tick & (ms_q == 11'h001);
	// Hold braking blocks restarts until its first 100 ms are over.
	assign may_start = (state_q == ABT_IDLE) | (state_q == ABT_HOLD); // RL9 RL10

	always_comb begin
		state_d = state_q;
		run_d = run_q;
		pre_d = tick ? 14'h0000 : pre_q + 14'h0001;
		ms_d = tick ? ms_q - 11'h001 : ms_q;
		if (trig & may_start) begin
			run_d = timing_cfg_q; // RL1 RL12
			state_d = ABT_ON;
			pre_d = 14'h0000; // RL19
			ms_d = abt_on_ms(timing_cfg_q.on_code);
		end else if (emcy_enter & ~override_q[`ABT_ACT_ON_WRITE_BIT] & (state_q != ABT_IDLE)) begin
			state_d = ABT_IDLE; // RL11
		end else begin
			unique case (state_q)
				ABT_IDLE: begin
					pre_d = 14'h0000;
				end
				ABT_ON: begin
					if (ms_done) begin
						pre_d = 14'h0000;
						ms_d = abt_brk_ms(run_q.brake_code);
						state_d = (run_q.brake_code == abt_pkg::ABT_BRK_NONE) ? ABT_IDLE : ABT_BRAKE; // RL5
					end
				end
				ABT_BRAKE: begin
					if (ms_done) begin
						state_d = (run_q.brake_code == abt_pkg::ABT_BRK_HOLD) ? ABT_HOLD : ABT_IDLE; // RL8
					end
				end
				ABT_HOLD: begin
					pre_d = 14'h0000;
				end
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= ABT_IDLE;
			run_q <= abt_pkg::abt_timing_cfg_t'(`ABT_TIMING_RESET);
			pre_q <= 14'h0000;
			ms_q <= 11'h000;
		end else if (clk_en) begin
			state_q <= state_d;
			run_q <= run_d;
			pre_q <= pre_d;
			ms_q <= ms_d;
		end
	end

	// ************************************************************
	// Output drive
	// ************************************************************
	logic [7:0] ovr, brk_mask, drive_d, low_d;
	logic act_d, brk_d;
	assign ovr = override_q[`ABT_OVR_HI:`ABT_OVR_LO] & {8{en_s2_q}};
	// Drive bits follow the next state, so they change in the same cycle as the status flags.
	assign brk_mask = ~{run_d.ext_brake_disable, run_d.internal_brake_disable} &
		~override_q[`ABT_OVR_HI:`ABT_OVR_LO]; // RL6 RL14
	always_comb begin
		drive_d = ovr; // RL18
		low_d = 8'h00;
		act_d = (state_d == ABT_ON);
		brk_d = (state_d == ABT_BRAKE) | (state_d == ABT_HOLD);
		if (act_d) begin
			drive_d = 8'hFF; // RL12
		end else if (brk_d) begin
			low_d = brk_mask; // RL7
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			drive_on_q <= 8'h00;
			low_side_on_q <= 8'h00;
			actuating_q <= 1'b0;
			braking_q <= 1'b0;
		end else if (clk_en) begin
			drive_on_q <= drive_d;
			low_side_on_q <= low_d;
			actuating_q <= act_d;
			braking_q <= brk_d;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_brake_follows_on: assert property (@(posedge mclk) disable iff (rst) // RL5
		clk_en & (state_q == ABT_ON) & ms_done & ~trig & ~emcy_enter &
		(run_q.brake_code != abt_pkg::ABT_BRK_NONE) |=> state_q == ABT_BRAKE)
		else $error("brake did not follow on-time");
	a_disabled_never_brakes: assert property (@(posedge mclk) disable iff (rst) // RL14
		(low_side_on_q & {run_q.ext_brake_disable, run_q.internal_brake_disable}) == 8'h00)
		else $error("disabled output braked");
	a_run_cfg_stable: assert property (@(posedge mclk) disable iff (rst) // RL1
		(state_q == ABT_ON) & ~trig |=> $stable(run_q))
		else $error("running config changed");
	a_no_restart_brake: assert property (@(posedge mclk) disable iff (rst) // RL9
		(state_q == ABT_BRAKE) & trig & ~emcy_enter |=> state_q != ABT_ON)
		else $error("restart during braking");
	a_cfg_kept: assert property (@(posedge mclk) disable iff (rst) // RL2
		~wr_tim |=> $stable(timing_cfg_q))
		else $error("config changed without write");
	a_emcy_stops_hold: assert property (@(posedge mclk) disable iff (rst) // RL11
		clk_en & (state_q == ABT_HOLD) & emcy_enter & ~trig &
		~override_q[`ABT_ACT_ON_WRITE_BIT] |=> state_q == ABT_IDLE)
		else $error("hold braking not stopped");
	a_trigger_starts: assert property (@(posedge mclk) disable iff (rst) // RL16
		clk_en & trig & (state_q == ABT_IDLE) |=> state_q == ABT_ON)
		else $error("trigger ignored");
	a_on_loads_time: assert property (@(posedge mclk) disable iff (rst) // RL13
		clk_en & trig & may_start |=> ms_q == abt_on_ms($past(timing_cfg_q.on_code)))
		else $error("wrong on-time load");
endmodule

// *** tb/abt_host_model.sv ***
`timescale 1ns/100ps
// ************************************************************
// Host side of the register write path
// ************************************************************
module abt_host_model (
	input wire logic mclk,
	output abt_pkg::abt_write_t wr,
	output logic cs_rise
);
	initial begin
		wr = '0;
		cs_rise = 1'b0;
	end
	// An idle bus shows the inverse of the last word, so stale data cannot pass for valid.
	task automatic write(input logic [5:0] addr, input logic [15:0] data, input bit rise);
		logic [15:0] word;
		word = {data[15:1], ~^data[15:1]};
		@(posedge mclk);
		wr <= '{valid: 1'b1, addr: addr, data: word};
		@(posedge mclk);
		wr <= '{valid: 1'b0, addr: ~addr, data: ~word};
		cs_rise <= rise;
		@(posedge mclk);
		cs_rise <= 1'b0;
	endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
	localparam int CYC = 10;
	typedef struct {logic [15:0] cfg; int on_ms; int brk_ms;} abt_row_t;
	logic mclk, rst, clk_en, enable_pin, cs_rise;
	abt_pkg::abt_write_t wr;
	abt_pkg::abt_timing_cfg_t timing_cfg_q;
	logic [15:0] override_q;
	logic [7:0] drive_on_q, low_side_on_q;
	logic actuating_q, braking_q;
	int n_mismatch = 0;
	int compares = 0;
	abt_row_t rows [4] = '{'{16'h0002, 100, 100}, '{16'h817C, 400, 200},
		'{16'h4280, 440, 0}, '{16'h3CFA, 1040, 100}};
	abt_host_model abt_host_model_inst (.mclk(mclk), .wr(wr), .cs_rise(cs_rise));
	abt_timing #(.CYC_PER_MS(CYC)) abt_timing_inst (.mclk(mclk), .rst(rst), .clk_en(clk_en),
		.wr(wr), .cs_rise(cs_rise), .enable_pin(enable_pin), .timing_cfg_q(timing_cfg_q),
		.override_q(override_q), .drive_on_q(drive_on_q), .low_side_on_q(low_side_on_q),
		.actuating_q(actuating_q), .braking_q(braking_q));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic summarize();
		$display("Mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			n_mismatch++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask
	// ************************************************************
	// One timed actuation, measured phase by phase
	// ************************************************************
	// Tolerance of one tick allows for where the millisecond prescaler sits.
	task automatic measure(input logic [15:0] cfg, input int on_ms, input int brk_ms,
		input bit hold);
		int n;
		n = 0;
		@(negedge mclk);
		while (drive_on_q !== 8'hFF) begin
			n++;
			if (n > 60) begin
				chk(1'b0, "no start");
				summarize();
			end
			@(negedge mclk);
		end
		chk(actuating_q === 1'b1, "busy flag");
		n = 0;
		while (drive_on_q === 8'hFF && n < 11000) begin
			n++;
			@(negedge mclk);
		end
		chk(n > (on_ms - 1) * CYC && n < (on_ms + 1) * CYC, "on time");
		chk(braking_q === (brk_ms != 0) && actuating_q === 1'b0, "brake start");
		n = 0;
		while (braking_q === 1'b1 && n < (brk_ms + 2) * CYC) begin
			chk(low_side_on_q === ~cfg[15:8], "brake mask");
			n++;
			@(negedge mclk);
		end
		if (hold) chk(braking_q === 1'b1, "hold ended");
		else chk(n > (brk_ms - 1) * CYC && n < (brk_ms + 1) * CYC, "brake time");
	endtask
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		enable_pin = 1'b1;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk(timing_cfg_q === 16'h0000 && override_q === 16'h0000, "reset regs");
		chk(drive_on_q === 8'h00 && low_side_on_q === 8'h00 && braking_q === 1'b0, "reset out");
		chk(actuating_q === 1'b0, "reset busy");
		abt_host_model_inst.write(6'h01, 16'h0002, 0);
		foreach (rows[i]) begin
			abt_host_model_inst.write(6'h02, rows[i].cfg, 1);
			measure(rows[i].cfg, rows[i].on_ms, rows[i].brk_ms, 0);
			chk(timing_cfg_q[15:1] === rows[i].cfg[15:1], "readback");
		end
		// ************************************************************
		// Indefinite braking: early trigger refused, then left by reprogramming
		// ************************************************************
		abt_host_model_inst.write(6'h02, 16'h0006, 1);
		fork
			measure(16'h0006, 100, 100, 1);
			begin
				repeat (150 * CYC) @(posedge mclk);
				abt_host_model_inst.write(6'h02, 16'h0006, 1);
			end
		join
		abt_host_model_inst.write(6'h02, 16'h0000, 1);
		measure(16'h0000, 100, 0, 0);
		abt_host_model_inst.write(6'h02, 16'h0006, 1);
		repeat (250 * CYC) @(posedge mclk);
		abt_host_model_inst.write(6'h01, 16'h00C0, 1);
		repeat (CYC) @(negedge mclk);
		chk(braking_q === 1'b1, "normal select stopped hold");
		abt_host_model_inst.write(6'h01, 16'h0080, 1);
		repeat (5) @(negedge mclk);
		chk(braking_q === 1'b0 && drive_on_q === 8'h00, "emergency kept hold");
		// ************************************************************
		// Enable-pin trigger and a write landing mid-actuation
		// ************************************************************
		abt_host_model_inst.write(6'h01, 16'h0000, 0);
		abt_host_model_inst.write(6'h02, 16'h0002, 1);
		repeat (5) @(negedge mclk);
		chk(drive_on_q === 8'h00, "chip-select trigger with bit clear");
		@(posedge mclk);
		enable_pin <= 1'b0;
		repeat (5) @(posedge mclk);
		enable_pin <= 1'b1;
		fork
			measure(16'h0002, 100, 100, 0);
			begin
				repeat (300) @(posedge mclk);
				abt_host_model_inst.write(6'h02, 16'h102C, 0);
			end
		join
		chk(timing_cfg_q[15:1] === 15'h0816, "late write lost");
		@(posedge mclk);
		enable_pin <= 1'b0;
		repeat (5) @(posedge mclk);
		enable_pin <= 1'b1;
		measure(16'h102C, 200, 200, 0);
		@(posedge mclk);
		clk_en <= 1'b0;
		abt_host_model_inst.write(6'h02, 16'h0000, 0);
		@(negedge mclk);
		chk(timing_cfg_q[15:1] === 15'h0816, "write taken while frozen");
		@(posedge mclk);
		clk_en <= 1'b1;
		summarize();
	end
endmodule
